// ---- design/eda_pkg.sv ----
// shared constants, types and lane functions for external bus data alignment
package eda_pkg;

  // ------------------------------------------------------------
  // widths and block geometry
  // ------------------------------------------------------------
  localparam int ADDR_W      = 32;
  localparam int ACC_W       = 64;
  localparam int BUS_W       = 32;
  localparam int LANES       = 4;
  localparam int BLOCK_LG    = 5;
  localparam logic [5:0] BLOCK_BYTES = 6'h20;
  localparam int SYNC_SETTLE = 2;
  localparam logic PIN_BIG_LEVEL = 1'b0;

  // ------------------------------------------------------------
  // access sizes, bus widths, memory kinds, states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {EDA_SZ_BYTE, EDA_SZ_WORD, EDA_SZ_LONG, EDA_SZ_QUAD} eda_size_t;
  typedef enum logic [1:0] {EDA_BW_8, EDA_BW_16, EDA_BW_32, EDA_BW_BAD} eda_width_t;
  typedef enum logic [1:0] {EDA_MEM_NORMAL, EDA_MEM_DRAM, EDA_MEM_SDRAM, EDA_MEM_PCMCIA} eda_mem_t;
  typedef enum {EDA_ST_INIT, EDA_ST_IDLE, EDA_ST_SETUP, EDA_ST_BUSCYC} eda_state_t;

  // legal bus width per memory kind
  function automatic logic eda_width_ok(eda_mem_t mem, eda_width_t w);
    unique case (mem)
      EDA_MEM_NORMAL: return w != EDA_BW_BAD;
      EDA_MEM_DRAM:   return w == EDA_BW_16 || w == EDA_BW_32;
      EDA_MEM_SDRAM:  return w == EDA_BW_32;
      EDA_MEM_PCMCIA: return w == EDA_BW_8 || w == EDA_BW_16;
    endcase
  endfunction

  // log2 of bytes moved per bus cycle: the narrower of access and bus
  function automatic logic [1:0] eda_step_lg(eda_width_t w, eda_size_t s);
    return (2'(s) < 2'(w)) ? 2'(s) : 2'(w);
  endfunction

  // byte lane that carries byte address a on a bus of width w
  function automatic logic [1:0] eda_lane_of(logic big, eda_width_t w, logic [2:0] a);
    unique case (w)
      EDA_BW_32: return big ? 2'h3 - a[1:0] : a[1:0];
      EDA_BW_16: return big ? {1'b0, ~a[0]} : {1'b0, a[0]};
      default:   return 2'h0;
    endcase
  endfunction

endpackage

// ---- design/eda_lane_steer.sv ----
// byte lane steering for one external bus cycle
`timescale 1ns/1ps
module eda_lane_steer
  (
    // cycle description
    input  wire logic                 big_endian,
    input  wire eda_pkg::eda_width_t  width,
    input  wire eda_pkg::eda_size_t   size,
    input  wire logic [2:0]           cyc_ofs,
    input  wire logic [2:0]           acc_ofs,
    input  wire logic [63:0]          wdata,
    // lane map
    output logic [3:0]                lane_en,
    output logic [3:0][2:0]           lane_idx,
    output logic [31:0]               lane_wdata
  );
  import eda_pkg::*;

  // ------------------------------------------------------------
  // map each byte of the cycle onto its lane
  // ------------------------------------------------------------
  // byte k of the access is data byte (1 << size)-1-k in big endian, k in little
  always_comb
  begin
    logic [2:0] a;
    logic [2:0] k;
    logic [2:0] idx;
    logic [1:0] ln;
    logic [3:0] n;
    a          = '0;
    k          = '0;
    idx        = '0;
    ln         = '0;
    n          = 4'h1 << eda_step_lg(width, size);
    lane_en    = '0;
    lane_idx   = '0;
    lane_wdata = '0;                                   // unused lanes read as zero
    for (int m = 0; m < LANES; m++)
    begin
      if (4'(m) < n)
      begin
        a   = cyc_ofs + 3'(m);
        k   = a - acc_ofs;
        idx = big_endian ? ((3'h1 << size) - 3'h1) - 3'(k) : k;
        ln  = eda_lane_of(big_endian, width, a);
        lane_en[ln]            = 1'b1;
        lane_idx[ln]           = idx;
        lane_wdata[ln*8 +: 8]  = wdata[idx*8 +: 8];
      end
    end
  end

endmodule

// ---- design/eda_align.sv ----
// external bus data alignment and width conversion engine
//
// How it works
// - endian pin sampled at power-on: low big
// - legal widths checked per memory kind
// - wide access split into consecutive bus cycles
// - longword on 8-bit bus: four byte cycles
// - 32-byte block starts at request, wraps around
// - bus kept and refresh held during transfers
// - quadword accepted only from dma controller
// - 32-bit big endian byte lane mapping
// - 32-bit big endian quadword high half first
// - 16-bit big endian byte lane mapping
// - 16-bit big endian halfwords, high first
// - 8-bit big endian lane 0, MSB first
// - 32-bit little endian lanes, low half first
// - 16-bit little endian, low halfword first
// - 8-bit little endian lane 0, LSB first
`timescale 1ns/1ps
module eda_align
  (
    // clock, reset, enable
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    // mode pin
    input  wire logic                 endian_select_pin,
    // access request from cpu or dma controller
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire logic                 req_write,
    input  wire eda_pkg::eda_size_t   req_size,
    input  wire logic [31:0]          req_addr,
    input  wire logic [63:0]          req_wdata,
    input  wire logic                 req_dma,
    input  wire logic                 req_block,
    input  wire eda_pkg::eda_width_t  req_width,
    input  wire eda_pkg::eda_mem_t    req_mem,
    output logic                      wdata_take,
    // answer to the requester
    output logic                      rsp_valid,
    output logic                      rsp_last,
    output logic                      rsp_err,
    output logic [63:0]               rsp_rdata,
    // external bus cycle port
    output logic                      cyc_valid,
    input  wire logic                 cyc_ready,
    output logic [31:0]               cyc_addr,
    output logic                      cyc_write,
    output logic [31:0]               cyc_wdata,
    output logic [3:0]                cyc_lane_en,
    input  wire logic [31:0]          cyc_rdata,
    // status
    output logic                      big_endian,
    output logic                      bus_owned,
    output logic                      refresh_hold
  );
  import eda_pkg::*;
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  eda_state_t  state_reg;
  eda_state_t  state_next;
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic [1:0]  settle_reg;
  logic        big_reg;
  eda_size_t   size_reg;
  eda_width_t  width_reg;
  logic        write_reg;
  logic        block_reg;
  logic [31:0] base_reg;
  logic [5:0]  done_reg;
  logic [63:0] unit_wdata_reg;
  logic [63:0] rbuf_reg;
  logic [3:0][2:0] cyc_idx_reg;
  logic        cyc_valid_reg;
  logic [31:0] cyc_addr_reg;
  logic [31:0] cyc_wdata_reg;
  logic [3:0]  cyc_lane_reg;
  logic        rsp_valid_reg;
  logic        rsp_last_reg;
  logic        rsp_err_reg;
  logic [63:0] rsp_rdata_reg;
  logic        accept;
  logic        bad_req;
  logic        ack;
  logic [5:0]  step;
  logic [5:0]  done_after;
  logic        unit_end;
  logic        xfer_end;
  logic [31:0] next_addr;
  logic [2:0]  acc_ofs;
  logic [3:0]  st_lane_en;
  logic [3:0][2:0] st_lane_idx;
  logic [31:0] st_lane_wdata;
  logic [63:0] rbuf_merged;
  // ------------------------------------------------------------
  // endian mode capture
  // ------------------------------------------------------------
  // pin is asynchronous to clk, so two flops before it is looked at
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
      pin_meta_reg <= endian_select_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end
  // latched once after reset release; later pin moves are ignored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_reg <= '0;
      big_reg    <= 1'b1;
    end
    else if (ce && state_reg == EDA_ST_INIT)
    begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == 2'(SYNC_SETTLE))
        big_reg <= (pin_sync_reg == PIN_BIG_LEVEL);
    end
  end
  // ------------------------------------------------------------
  // request checks and cycle arithmetic
  // ------------------------------------------------------------
  assign req_ready = (state_reg == EDA_ST_IDLE);
  assign accept    = req_valid && req_ready;
  // bad width, cpu quadword or misaligned start are answered with an error
  assign bad_req   = !eda_width_ok(req_mem, req_width)
                   || (req_size == EDA_SZ_QUAD && !req_dma)
                   || ((req_addr[2:0] & ((3'h1 << req_size) - 3'h1)) != 3'h0);
  assign ack       = ce && (state_reg == EDA_ST_BUSCYC) && cyc_ready;  // frozen: no ack
  // bytes per cycle is the narrower of access size and bus width
  assign step       = 6'h1 << eda_step_lg(width_reg, size_reg);
  assign done_after = done_reg + step;
  assign unit_end   = (done_after & ((6'h1 << size_reg) - 6'h1)) == 6'h0;
  assign xfer_end   = block_reg ? (done_after == BLOCK_BYTES)
                                : unit_end;
  // block cycles wrap inside the aligned 32-byte window
  always_comb
  begin
    if (block_reg)
      next_addr = {base_reg[31:BLOCK_LG],
                   5'(base_reg[BLOCK_LG-1:0] + done_reg[BLOCK_LG-1:0])};
    else
      next_addr = base_reg + {26'h0, done_reg};
  end

  // start of the access unit now in flight, for byte numbering
  assign acc_ofs = 3'(next_addr[2:0] & ~((3'h1 << size_reg) - 3'h1));
  // ------------------------------------------------------------
  // lane steering for the cycle being set up
  // ------------------------------------------------------------
  eda_lane_steer u_steer
  (
    .big_endian (big_reg),
    .width      (width_reg),
    .size       (size_reg),
    .cyc_ofs    (next_addr[2:0]),
    .acc_ofs    (acc_ofs),
    .wdata      (unit_wdata_reg),
    .lane_en    (st_lane_en),
    .lane_idx   (st_lane_idx),
    .lane_wdata (st_lane_wdata)
  );

  // read lanes land in the data byte they were steered from
  always_comb
  begin
    rbuf_merged = rbuf_reg;
    for (int j = 0; j < LANES; j++)
    begin
      if (cyc_lane_reg[j])
        rbuf_merged[cyc_idx_reg[j]*8 +: 8] = cyc_rdata[j*8 +: 8];
    end
  end
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      EDA_ST_INIT:
        if (settle_reg == 2'(SYNC_SETTLE))
          state_next = EDA_ST_IDLE;
      EDA_ST_IDLE:
        if (accept && !bad_req)
          state_next = EDA_ST_SETUP;
      EDA_ST_SETUP:
        state_next = EDA_ST_BUSCYC;
      EDA_ST_BUSCYC:
        if (cyc_ready)
          state_next = xfer_end ? EDA_ST_IDLE : EDA_ST_SETUP;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= EDA_ST_INIT;
    else if (ce)
      state_reg <= state_next;
  end
  // ------------------------------------------------------------
  // transfer context
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      size_reg  <= EDA_SZ_BYTE;
      width_reg <= EDA_BW_32;
      write_reg <= 1'b0;
      block_reg <= 1'b0;
      base_reg  <= '0;
      done_reg  <= '0;
    end
    else if (ce)
    begin
      if (accept)
      begin
        size_reg  <= req_size;
        width_reg <= req_width;
        write_reg <= req_write;
        block_reg <= req_block;
        base_reg  <= req_addr;
        done_reg  <= '0;
      end
      else if (ack)
        done_reg <= done_after;
    end
  end

  // next unit of a block write is taken as the previous one finishes
  assign wdata_take = ack && unit_end && !xfer_end && write_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_wdata_reg <= '0;
    else if (ce && (accept || wdata_take))
      unit_wdata_reg <= req_wdata;
  end
  // ------------------------------------------------------------
  // external cycle outputs
  // ------------------------------------------------------------
  // registered so lanes and address are stable for the whole cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_valid_reg <= 1'b0;
      cyc_addr_reg  <= '0;
      cyc_wdata_reg <= '0;
      cyc_lane_reg  <= '0;
      cyc_idx_reg   <= '0;
    end
    else if (ce)
    begin
      if (state_reg == EDA_ST_SETUP)
      begin
        cyc_valid_reg <= 1'b1;
        cyc_addr_reg  <= next_addr;
        cyc_wdata_reg <= st_lane_wdata;
        cyc_lane_reg  <= st_lane_en;
        cyc_idx_reg   <= st_lane_idx;
      end
      else if (ack)
      begin
        cyc_valid_reg <= 1'b0;
        cyc_lane_reg  <= '0;
      end
    end
  end
  // ------------------------------------------------------------
  // read gather and answers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rbuf_reg <= '0;
    else if (ce)
    begin
      if (accept || (ack && unit_end))
        rbuf_reg <= '0;
      else if (ack)
        rbuf_reg <= rbuf_merged;
    end
  end

  // one pulse per finished unit, or one error pulse for a refused request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_last_reg  <= 1'b0;
      rsp_err_reg   <= 1'b0;
      rsp_rdata_reg <= '0;
    end
    else if (ce)
    begin
      rsp_valid_reg <= (accept && bad_req) || (ack && unit_end);
      rsp_last_reg  <= (accept && bad_req) || (ack && xfer_end);
      rsp_err_reg   <= accept && bad_req;
      if (ack && unit_end)
        rsp_rdata_reg <= write_reg ? 64'h0 : rbuf_merged;
    end
  end
  // ------------------------------------------------------------
  // port drive
  // ------------------------------------------------------------
  assign cyc_valid    = cyc_valid_reg;
  assign cyc_addr     = cyc_addr_reg;
  assign cyc_write    = write_reg;
  assign cyc_wdata    = cyc_wdata_reg;
  assign cyc_lane_en  = cyc_lane_reg;
  assign rsp_valid    = rsp_valid_reg;
  assign rsp_last     = rsp_last_reg;
  assign rsp_err      = rsp_err_reg;
  assign rsp_rdata    = rsp_rdata_reg;
  assign big_endian   = big_reg;
  // bus stays owned, refresh held, from setup of the first cycle to the last ack
  assign bus_owned    = (state_reg == EDA_ST_SETUP) || (state_reg == EDA_ST_BUSCYC);
  assign refresh_hold = bus_owned;

endmodule

// ---- bench/eda_align_asserts.sv ----
// assertion checker for the external bus alignment engine
`timescale 1ns/1ps
module eda_align_asserts
  (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst_n,
    // mode and request side
    input wire logic               endian_select_pin,
    input wire logic               req_valid,
    input wire logic               req_ready,
    input wire eda_pkg::eda_size_t  req_size,
    input wire logic               req_dma,
    input wire logic               req_block,
    input wire eda_pkg::eda_width_t req_width,
    input wire eda_pkg::eda_mem_t   req_mem,
    input wire logic               rsp_valid,
    input wire logic               rsp_err,
    // bus cycle side and status
    input wire logic               cyc_valid,
    input wire logic               cyc_ready,
    input wire logic [31:0]        cyc_addr,
    input wire logic [3:0]         cyc_lane_en,
    input wire logic               big_endian,
    input wire logic               bus_owned,
    input wire logic               refresh_hold
  );
  import eda_pkg::*;
  logic       take;
  logic       bad_w;
  logic [4:0] step;
  logic [3:0] lane32;

  // ------------------------------------------------------------
  // helper terms
  // ------------------------------------------------------------
  // request fields are held by the requester for the whole transfer
  assign take = req_valid && req_ready;
  assign bad_w = req_width == EDA_BW_BAD || (req_mem == EDA_MEM_DRAM && req_width == EDA_BW_8)
    || (req_mem == EDA_MEM_SDRAM && req_width != EDA_BW_32)
    || (req_mem == EDA_MEM_PCMCIA && req_width == EDA_BW_32);
  assign step = 5'h1 << ((2'(req_size) < 2'(req_width)) ? 2'(req_size) : 2'(req_width));
  assign lane32 = req_size == EDA_SZ_BYTE
    ? (big_endian ? 4'h8 >> cyc_addr[1:0] : 4'h1 << cyc_addr[1:0])
    : req_size == EDA_SZ_WORD ? ((big_endian ^ cyc_addr[1]) ? 4'hc : 4'h3) : 4'hf;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ENDIAN: assert property (req_ready |-> big_endian == !endian_select_pin)
    else $error("endian mode differs from pin level");
  AST_BAD_WIDTH: assert property (take && bad_w |=> rsp_valid && rsp_err && !cyc_valid)
    else $error("illegal width not refused");
  AST_QUAD_CPU: assert property (take && req_size == EDA_SZ_QUAD && !req_dma |=> rsp_err)
    else $error("processor quadword not refused");
  AST_OWNED: assert property (cyc_valid |-> bus_owned && refresh_hold)
    else $error("bus cycle without ownership");
  AST_KEEP: assert property (bus_owned && !(cyc_valid && cyc_ready) |=> bus_owned)
    else $error("bus released mid transfer");
  AST_STEP: assert property (cyc_valid && cyc_ready ##1 bus_owned |=> cyc_valid
    && 5'(cyc_addr - $past(cyc_addr, 2)) == step && (cyc_addr ^ $past(cyc_addr, 2)) < 32'h20)
    else $error("next cycle address wrong");
  AST_LANE8: assert property (cyc_valid && req_width == EDA_BW_8 |-> cyc_lane_en == 4'h1)
    else $error("8-bit strobes wrong");
  AST_LANE16: assert property (cyc_valid && req_width == EDA_BW_16 |-> cyc_lane_en ==
    (req_size != EDA_SZ_BYTE ? 4'h3 : (big_endian ^ cyc_addr[0]) ? 4'h2 : 4'h1))
    else $error("16-bit strobes wrong");
  AST_LANE32: assert property (cyc_valid && req_width == EDA_BW_32 |-> cyc_lane_en == lane32)
    else $error("32-bit strobes wrong");

  COV_BLOCK: cover property (take && req_block);
  COV_QUAD: cover property (take && req_dma && req_size == EDA_SZ_QUAD);
  COV_ERR: cover property (rsp_valid && rsp_err);
endmodule

bind eda_align eda_align_asserts i_chk (.clk, .rst_n, .endian_select_pin, .req_valid,
  .req_ready, .req_size, .req_dma, .req_block, .req_width, .req_mem, .rsp_valid, .rsp_err,
  .cyc_valid, .cyc_ready, .cyc_addr, .cyc_lane_en, .big_endian, .bus_owned, .refresh_hold);

// ---- bench/eda_mem_model.sv ----
// behavioural external memory answering bus cycles after a chosen wait
`timescale 1ns/1ps
module eda_mem_model
  (
    // clock and pacing
    input wire logic               clk,
    input wire logic [1:0]         wait_n,
    // lane convention
    input wire logic               big,
    input wire eda_pkg::eda_width_t width,
    // bus cycle port
    input wire logic               cyc_valid,
    output logic                   cyc_ready,
    input wire logic [31:0]        cyc_addr,
    input wire logic               cyc_write,
    input wire logic [31:0]        cyc_wdata,
    input wire logic [3:0]         cyc_lane_en,
    output logic [31:0]            cyc_rdata
  );
  import eda_pkg::*;
  logic [7:0] mem [256];
  logic [1:0] cnt;
  logic [7:0] tick;

  // byte address that lane j carries on this bus
  function automatic logic [7:0] lane_adr(logic [1:0] j);
    case (width)
      EDA_BW_32: return {cyc_addr[7:2], big ? ~j : j};
      EDA_BW_16: return {cyc_addr[7:1], big ^ j[0]};
      default:   return cyc_addr[7:0];
    endcase
  endfunction

  // known contents so reads can be predicted
  initial
  begin
    cyc_ready = 1'b0;
    cnt = 2'h0;
    tick = 8'h0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
  end

  // ack raised on the (wait_n+1)th edge that sees the cycle valid; only strobed lanes are stored
  always @(posedge clk)
  begin
    tick <= tick + 8'h3b;
    cyc_ready <= cyc_valid && !cyc_ready && cnt >= wait_n;
    cnt <= cyc_valid ? cnt + 2'h1 : 2'h0;
    if (cyc_valid && cyc_ready && cyc_write)
      for (int j = 0; j < 4; j++)
        if (cyc_lane_en[j])
          mem[lane_adr(2'(j))] <= cyc_wdata[8*j+:8];
  end

  // outside the ack or the width the lanes churn, never a stale value
  always_comb
    for (int j = 0; j < 4; j++)
      cyc_rdata[8*j+:8] = (cyc_ready && j < (1 << 2'(width))) ? mem[lane_adr(2'(j))]
        : tick ^ 8'(j);
endmodule

// ---- bench/external_bus_data_alignment_test.sv ----
// self-checking bench for the external bus alignment engine
`timescale 1ns/1ps
module external_bus_data_alignment_test;
  import eda_pkg::*;
  logic        clk, rst_n = 0, ce = 1, pin = 0, req_valid = 0, req_write = 0;
  logic        req_dma = 0, req_block = 0, req_ready, wdata_take, rsp_valid, rsp_last;
  logic        rsp_err, cyc_valid, cyc_ready, cyc_write, big_endian, bus_owned, refresh_hold;
  eda_size_t   req_size = EDA_SZ_BYTE;
  eda_width_t  req_width = EDA_BW_32;
  eda_mem_t    req_mem = EDA_MEM_NORMAL;
  logic [31:0] req_addr = 0, cyc_addr, cyc_wdata, cyc_rdata, seed = 32'h4fd4;
  logic [63:0] req_wdata = 0, rsp_rdata;
  logic [3:0]  cyc_lane_en;
  logic [1:0]  wait_n = 0;
  logic [7:0]  sh [256];
  int          errors = 0, samples_checked = 0;

  eda_align i_dut (.clk, .rst_n, .ce, .endian_select_pin(pin), .req_valid, .req_ready,
    .req_write, .req_size, .req_addr, .req_wdata, .req_dma, .req_block, .req_width,
    .req_mem, .wdata_take, .rsp_valid, .rsp_last, .rsp_err, .rsp_rdata, .cyc_valid,
    .cyc_ready, .cyc_addr, .cyc_write, .cyc_wdata, .cyc_lane_en, .cyc_rdata,
    .big_endian, .bus_owned, .refresh_hold);
  eda_mem_model i_mem (.clk, .wait_n, .big(!pin), .width(req_width), .cyc_valid,
    .cyc_ready, .cyc_addr, .cyc_write, .cyc_wdata, .cyc_lane_en, .cyc_rdata);

  // 40 MHz clock
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bytes from the shadow; lowest address is most significant when big
  function automatic logic [63:0] exp_rd(logic [7:0] a, int n);
    logic [63:0] r;
    r = 0;
    for (int k = 0; k < n; k++)
      r = pin ? r | (64'(sh[8'(a + k)]) << (8 * k)) : (r << 8) | 64'(sh[8'(a + k)]);
    return r;
  endfunction
  function automatic logic [63:0] dat(int u);
    return {seed ^ 32'(u), ~seed + 32'(u)};
  endfunction
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access: drive at falling edges, follow every unit to its answer
  task automatic run(logic w, eda_size_t sz, logic [31:0] a, logic dma, logic blk,
                     eda_width_t wd, eda_mem_t mm);
    int n, units, u, k, t;
    logic e;
    logic [7:0] ua;
    seed = lfsr(seed);
    n = 1 << sz;
    units = blk ? 32 / n : 1;
    u = 0;
    k = 1;
    t = 0;
    req_write = w;
    req_size = sz;
    req_addr = a;
    req_dma = dma;
    req_block = blk;
    req_width = wd;
    req_mem = mm;
    req_wdata = dat(0);
    wait_n = seed[1:0];
    e = wd == EDA_BW_BAD || (mm == EDA_MEM_DRAM && wd == EDA_BW_8)
      || (mm == EDA_MEM_SDRAM && wd != EDA_BW_32) || (mm == EDA_MEM_PCMCIA && wd == EDA_BW_32)
      || (sz == EDA_SZ_QUAD && !dma) || (a & (n - 1)) != 0;
    req_valid = 1;
    while (!req_ready && t < 50)
    begin
      @(negedge clk);
      t++;
    end
    @(negedge clk);
    req_valid = 0;
    while (u < units && t < 3000)
    begin
      if (wdata_take)
      begin
        req_wdata = dat(k);
        k++;
      end
      if (rsp_valid)
      begin
        ua = {a[7:5], 5'(a[4:0] + u * n)};
        chk(rsp_err, e);
        chk(rsp_last, e || u == units - 1);
        if (!e)
          chk(rsp_rdata, w ? 64'h0 : exp_rd(ua, n));
        for (int b = 0; b < n && w && !e; b++)
          sh[8'(ua + b)] = dat(u) >> (8 * (pin ? b : n - 1 - b));
        u = e ? units : u + 1;
      end
      @(negedge clk);
      t++;
    end
    if (u < units)
      chk(64'(u), 64'(units));
  endtask

  task automatic print_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence: corners then random, once per endian mode
  // ------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 256; i++)
      sh[i] = 8'(i) ^ 8'ha5;
    for (int p = 0; p < 2; p++)
    begin
      @(negedge clk);
      rst_n = 0;
      pin = p[0];
      repeat (2) @(negedge clk);
      rst_n = 1;
      // enable low must freeze the mode capture, so no request is offered yet
      ce = 0;
      repeat (6) @(negedge clk);
      chk(req_ready, 0);
      ce = 1;
      run(0, EDA_SZ_LONG, 32'h100, 0, 0, EDA_BW_8, EDA_MEM_NORMAL);
      run(1, EDA_SZ_QUAD, 32'h108, 1, 0, EDA_BW_32, EDA_MEM_SDRAM);
      run(0, EDA_SZ_QUAD, 32'h108, 1, 0, EDA_BW_16, EDA_MEM_DRAM);
      run(0, EDA_SZ_QUAD, 32'h110, 0, 0, EDA_BW_32, EDA_MEM_NORMAL);
      run(0, EDA_SZ_BYTE, 32'h110, 0, 0, EDA_BW_8, EDA_MEM_SDRAM);
      run(1, EDA_SZ_WORD, 32'h134, 0, 1, EDA_BW_16, EDA_MEM_PCMCIA);
      run(0, EDA_SZ_LONG, 32'h134, 0, 1, EDA_BW_8, EDA_MEM_NORMAL);
      for (int i = 0; i < 4; i++)
        run(0, EDA_SZ_BYTE, 32'h121 + i, 0, 0, EDA_BW_32, EDA_MEM_NORMAL);
      chk(big_endian, !pin);
      repeat (60)
        run(seed[2], eda_size_t'(seed[4:3]), {24'h1, seed[12:8], (seed[13] & seed[14])
          ? seed[7:5] : 3'h0}, seed[15], seed[16], eda_width_t'(seed[18:17]),
          eda_mem_t'(seed[20:19]));
    end
    print_verdict;
  end

  // hang guard, well beyond the expected run length
  initial
  begin
    #1000000;
    errors++;
    print_verdict;
  end
endmodule
